/* File: inc/irq_pkg.sv */
// Constants for the primary interrupt flag and enable registers.
// Assumes an APB slave with 32-bit data and byte addresses.
package irq_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [11:0] ADDR_CTRL_A = 12'h000;
  localparam logic [11:0] ADDR_CTRL_B = 12'h004;
  localparam logic [7:0]  RST_CTRL    = 8'h00;

  // ----------------------------------------
  // Source indices, highest priority first
  // ----------------------------------------
  localparam int          NUM_SRC = 7;
  localparam logic [2:0]  SRC_EXT = 3'h0;
  localparam logic [2:0]  SRC_AC  = 3'h1;
  localparam logic [2:0]  SRC_T0  = 3'h2;
  localparam logic [2:0]  SRC_SI  = 3'h3;
  localparam logic [2:0]  SRC_MF  = 3'h4;
  localparam logic [2:0]  SRC_T1  = 3'h5;
  localparam logic [2:0]  SRC_LV  = 3'h6;

  // ----------------------------------------
  // Field positions, first register
  // ----------------------------------------
  localparam int A_T0_FLAG = 6;
  localparam int A_AC_FLAG = 5;
  localparam int A_EX_FLAG = 4;
  localparam int A_T0_EN   = 3;
  localparam int A_AC_EN   = 2;
  localparam int A_EX_EN   = 1;
  localparam int A_GIE     = 0;

  // ----------------------------------------
  // Field positions, second register
  // ----------------------------------------
  localparam int B_LV_FLAG = 7;
  localparam int B_MF_FLAG = 6;
  localparam int B_SI_FLAG = 5;
  localparam int B_T1_FLAG = 4;
  localparam int B_LV_EN   = 3;
  localparam int B_MF_EN   = 2;
  localparam int B_SI_EN   = 1;
  localparam int B_T1_EN   = 0;

endpackage

/* File: verilog/irq_regs.sv */
// Primary interrupt request flags, enables and global enable.
// Assumes event pulses and the core acknowledge come from pclk logic.
//
// Contract
// - Timer 0 events set the flag at bit 6 of the first register.
// - The auto conversion flag sits at bit 5 of the first register.
// - The external pin flag sits at bit 4 of the first register.
// - Bit 3 of the first register enables timer 0 interrupts.
// - Bit 2 of the first register enables auto conversion interrupts.
// - Bit 1 of the first register enables external pin interrupts.
// - The low voltage flag sits at bit 7 of the second register.
// - The multi-function flag sits at bit 6 of the second register.
// - The serial interface flag sits at bit 5 of the second register.
// - The timer 1 flag sits at bit 4 of the second register.
// - Bit 1 of the second register enables serial interface interrupts.
// - Bit 0 of the second register enables timer 1 interrupts.
// - Flags set regardless of enables; a request needs source and global enable.
// - Taking an interrupt clears the global enable while flags still record.
// - Servicing external pin or auto conversion clears that source's flag.

`timescale 1ns/100ps
`default_nettype none

module irq_regs
  import irq_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Peripheral event pulses
  input  wire logic              timer0_evt,
  input  wire logic              autoconv_evt,
  input  wire logic              ext_pin_evt,
  input  wire logic              lowvolt_evt,
  input  wire logic              multifunc_evt,
  input  wire logic              serial_if_evt,
  input  wire logic              timer1_evt,
  // Core vectoring
  input  wire logic              irq_ack,
  output logic                   irq_req,
  output logic      [2:0]        irq_id
);

  // ----------------------------------------
  // Elaboration check
  // ----------------------------------------
  if (ADDR_W < 3 || ADDR_W > 12)
  begin : g_bad_addr
    $error("ADDR_W must lie between 3 and 12");
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [NUM_SRC-1:0] flag_q;
  logic [NUM_SRC-1:0] flag_d;
  logic [NUM_SRC-1:0] en_q;
  logic [NUM_SRC-1:0] en_d;
  logic               gie_q;
  logic               gie_d;
  logic [31:0]        prdata_q;
  logic               pready_q;
  logic               pslverr_q;
  logic               irq_req_q;
  logic [2:0]         irq_id_q;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire logic [11:0]        addr_w;
  wire logic               hit_a;
  wire logic               hit_b;
  wire logic               setup;
  wire logic               wr_now;
  wire logic               wr_a;
  wire logic               wr_b;
  wire logic [7:0]         rd_a;
  wire logic [7:0]         rd_b;
  wire logic [7:0]         rd_sel;
  wire logic [NUM_SRC-1:0] wsel;
  wire logic [NUM_SRC-1:0] wflag;
  wire logic [NUM_SRC-1:0] wen;
  wire logic [NUM_SRC-1:0] evt;
  wire logic [NUM_SRC-1:0] clr;
  wire logic [NUM_SRC-1:0] pend;
  wire logic               take;

  assign addr_w = 12'(paddr);
  assign hit_a  = (addr_w == ADDR_CTRL_A);
  assign hit_b  = (addr_w == ADDR_CTRL_B);
  assign setup  = psel & ~penable;
  // The write lands on the access edge that completes the transfer.
  assign wr_now = psel & penable & pready_q & pwrite & ~pslverr_q;
  assign wr_a   = wr_now & hit_a;
  assign wr_b   = wr_now & hit_b;

  // ----------------------------------------
  // Read images
  // ----------------------------------------
  assign rd_a[7] = 1'b0;
  assign rd_a[A_T0_FLAG] = flag_q[SRC_T0];
  assign rd_a[A_AC_FLAG] = flag_q[SRC_AC];
  assign rd_a[A_EX_FLAG] = flag_q[SRC_EXT];
  assign rd_a[A_T0_EN]   = en_q[SRC_T0];
  assign rd_a[A_AC_EN]   = en_q[SRC_AC];
  assign rd_a[A_EX_EN]   = en_q[SRC_EXT];
  assign rd_a[A_GIE]     = gie_q;
  assign rd_b[B_LV_FLAG] = flag_q[SRC_LV];
  assign rd_b[B_MF_FLAG] = flag_q[SRC_MF];
  assign rd_b[B_SI_FLAG] = flag_q[SRC_SI];
  assign rd_b[B_T1_FLAG] = flag_q[SRC_T1];
  assign rd_b[B_LV_EN]   = en_q[SRC_LV];
  assign rd_b[B_MF_EN]   = en_q[SRC_MF];
  assign rd_b[B_SI_EN]   = en_q[SRC_SI];
  assign rd_b[B_T1_EN]   = en_q[SRC_T1];
  assign rd_sel = hit_a ? rd_a : (hit_b ? rd_b : 8'h00);

  // ----------------------------------------
  // Write images
  // ----------------------------------------
  assign wsel[SRC_EXT]  = wr_a;
  assign wsel[SRC_AC]   = wr_a;
  assign wsel[SRC_T0]   = wr_a;
  assign wsel[SRC_SI]   = wr_b;
  assign wsel[SRC_MF]   = wr_b;
  assign wsel[SRC_T1]   = wr_b;
  assign wsel[SRC_LV]   = wr_b;
  assign wflag[SRC_EXT] = pwdata[A_EX_FLAG];
  assign wflag[SRC_AC]  = pwdata[A_AC_FLAG];
  assign wflag[SRC_T0]  = pwdata[A_T0_FLAG];
  assign wflag[SRC_SI]  = pwdata[B_SI_FLAG];
  assign wflag[SRC_MF]  = pwdata[B_MF_FLAG];
  assign wflag[SRC_T1]  = pwdata[B_T1_FLAG];
  assign wflag[SRC_LV]  = pwdata[B_LV_FLAG];
  assign wen[SRC_EXT]   = pwdata[A_EX_EN];
  assign wen[SRC_AC]    = pwdata[A_AC_EN];
  assign wen[SRC_T0]    = pwdata[A_T0_EN];
  assign wen[SRC_SI]    = pwdata[B_SI_EN];
  assign wen[SRC_MF]    = pwdata[B_MF_EN];
  assign wen[SRC_T1]    = pwdata[B_T1_EN];
  assign wen[SRC_LV]    = pwdata[B_LV_EN];

  // ----------------------------------------
  // Events and service
  // ----------------------------------------
  assign evt[SRC_EXT] = ext_pin_evt;
  assign evt[SRC_AC]  = autoconv_evt;
  assign evt[SRC_T0]  = timer0_evt;
  assign evt[SRC_SI]  = serial_if_evt;
  assign evt[SRC_MF]  = multifunc_evt;
  assign evt[SRC_T1]  = timer1_evt;
  assign evt[SRC_LV]  = lowvolt_evt;

  // An acknowledge with no request standing is ignored.
  assign take = irq_ack & irq_req_q;
  assign pend = flag_q & en_q & {NUM_SRC{gie_q}};

  // Only these two sources clear themselves; the rest need software.
  assign clr[SRC_EXT] = take & (irq_id_q == SRC_EXT);
  assign clr[SRC_AC]  = take & (irq_id_q == SRC_AC);
  assign clr[SRC_T0]  = 1'b0;
  assign clr[SRC_SI]  = 1'b0;
  assign clr[SRC_MF]  = 1'b0;
  assign clr[SRC_T1]  = 1'b0;
  assign clr[SRC_LV]  = 1'b0;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  // A new event always wins, so a request never slips past a clear.
  for (genvar i = 0; i < NUM_SRC; i++)
  begin : g_src
    assign flag_d[i] = evt[i] | (wsel[i] ? wflag[i] : (flag_q[i] & ~clr[i]));
    assign en_d[i]   = wsel[i] ? wen[i] : en_q[i];
  end

  // The hardware clear beats a software set in the same cycle.
  assign gie_d = take ? 1'b0 : (wr_a ? pwdata[A_GIE] : gie_q);

  // ----------------------------------------
  // Priority encoder
  // ----------------------------------------
  function automatic logic [2:0] first_set(input logic [NUM_SRC-1:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int k = NUM_SRC - 1; k >= 0; k--)
    begin
      if (v[k])
      begin
        r = 3'(k);
      end
    end
    return r;
  endfunction

  wire logic       req_d;
  wire logic [2:0] id_d;

  assign req_d = (|pend) & ~take;
  assign id_d  = first_set(pend);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flag_q <= '0;
      en_q   <= '0;
      gie_q  <= RST_CTRL[A_GIE];
    end
    else
    begin
      flag_q <= flag_d;
      en_q   <= en_d;
      gie_q  <= gie_d;
    end
  end

  // One wait-free access phase: ready follows every setup cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q  <= '0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q  <= setup;
      pslverr_q <= setup & ~hit_a & ~hit_b;
      prdata_q  <= (setup & ~pwrite) ? {24'h000000, rd_sel} : 32'h00000000;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_req_q <= 1'b0;
      irq_id_q  <= 3'h0;
    end
    else
    begin
      irq_req_q <= req_d;
      irq_id_q  <= id_d;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign irq_req = irq_req_q;
  assign irq_id  = irq_id_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  gie_cleared_a: assert property (@(posedge pclk) disable iff (!presetn)
    take |=> !gie_q)
    else $error("Global enable not cleared after take");

  req_needs_en_a: assert property (@(posedge pclk) disable iff (!presetn)
    irq_req_q |-> $past(gie_q) && ($past(flag_q & en_q) != '0))
    else $error("Request raised without enables");

  req_when_en_a: assert property (@(posedge pclk) disable iff (!presetn)
    ((|(flag_q & en_q)) && gie_q && !take) |=> irq_req_q)
    else $error("Enabled request not raised");

  t0_sets_a: assert property (@(posedge pclk) disable iff (!presetn)
    timer0_evt |=> rd_a[A_T0_FLAG])
    else $error("Timer 0 flag not set by event");

  ac_sets_a: assert property (@(posedge pclk) disable iff (!presetn)
    autoconv_evt |=> rd_a[A_AC_FLAG])
    else $error("Auto conversion flag not set by event");

  ext_sets_a: assert property (@(posedge pclk) disable iff (!presetn)
    ext_pin_evt |=> rd_a[A_EX_FLAG])
    else $error("External flag not set by event");

  lv_sets_a: assert property (@(posedge pclk) disable iff (!presetn)
    lowvolt_evt |=> rd_b[B_LV_FLAG])
    else $error("Low voltage flag not set by event");

  mf_sets_a: assert property (@(posedge pclk) disable iff (!presetn)
    multifunc_evt |=> rd_b[B_MF_FLAG])
    else $error("Multi-function flag not set by event");

  si_sets_a: assert property (@(posedge pclk) disable iff (!presetn)
    serial_if_evt |=> rd_b[B_SI_FLAG])
    else $error("Serial flag not set by event");

  t1_sets_a: assert property (@(posedge pclk) disable iff (!presetn)
    timer1_evt |=> rd_b[B_T1_FLAG])
    else $error("Timer 1 flag not set by event");

  ext_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (take && irq_id_q == SRC_EXT && !ext_pin_evt && !wr_a)
      |=> !flag_q[SRC_EXT])
    else $error("External flag not cleared on service");

  ac_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (take && irq_id_q == SRC_AC && !autoconv_evt && !wr_a)
      |=> !flag_q[SRC_AC])
    else $error("Auto conversion flag not cleared on service");

  top_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && hit_a && !pwrite) |=> prdata_q[31:7] == '0)
    else $error("Unused bits of first register read nonzero");

  t0_en_wr_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_a |=> en_q[SRC_T0] == $past(pwdata[A_T0_EN]))
    else $error("Timer 0 enable not written");

  si_en_wr_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_b |=> rd_b[B_SI_EN] == $past(pwdata[B_SI_EN]))
    else $error("Serial enable not written");

  t1_en_wr_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_b |=> rd_b[B_T1_EN] == $past(pwdata[B_T1_EN]))
    else $error("Timer 1 enable not written");

  no_global_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!gie_q && !wr_a) [*2] |-> !irq_req_q)
    else $error("Request while global enable clear");

  ready_once_a: assert property (@(posedge pclk) disable iff (!presetn)
    setup |=> pready_q ##1 !pready_q)
    else $error("Ready not a single access cycle");

endmodule

`default_nettype wire

/* File: sim/core_model.sv */
// Behavioural processor core that takes the interrupt shown on irq_id.
// Assumes irq_req and irq_id are registered outputs in the pclk domain.
`timescale 1ns/100ps
`default_nettype none
module core_model (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Vectoring
  input  wire logic       irq_req,
  input  wire logic [2:0] irq_id,
  input  wire logic [3:0] lat,
  output logic            irq_ack,
  output logic      [2:0] taken_id
);
  logic [3:0] wait_q;
  // One ack pulse after lat cycles; the pulse itself blocks a second ack,
  // since the request only drops in the cycle after it.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wait_q   <= 4'h0;
      irq_ack  <= 1'b0;
      taken_id <= 3'h0;
    end
    else
    begin
      irq_ack <= 1'b0;
      if (irq_req && !irq_ack && wait_q >= lat)
      begin
        irq_ack  <= 1'b1;
        taken_id <= irq_id;
        wait_q   <= 4'h0;
      end
      else if (irq_req && !irq_ack)
        wait_q <= wait_q + 4'h1;
      else
        wait_q <= 4'h0;
    end
  end
endmodule
`default_nettype wire

/* File: sim/primary_irq_flag_enable_regs_tb.sv */
// Testbench for the primary interrupt flag and enable registers.
// Assumes a zero-wait APB slave and core_model on the vectoring side.
`timescale 1ns/100ps
`default_nettype none
module primary_irq_flag_enable_regs_tb;
  import irq_pkg::*;
  localparam int FB[7] = '{A_EX_FLAG, A_AC_FLAG, A_T0_FLAG, B_SI_FLAG, B_MF_FLAG,
                           B_T1_FLAG, B_LV_FLAG};
  localparam int EB[7] = '{A_EX_EN, A_AC_EN, A_T0_EN, B_SI_EN, B_MF_EN, B_T1_EN, B_LV_EN};
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [6:0]  evt = 7'h00;
  logic [3:0]  lat = 4'h0;
  logic        irq_ack;
  logic        irq_req;
  logic [2:0]  irq_id;
  logic [2:0]  taken_id;
  int          err_count = 0;
  int          checks = 0;

  always #4 pclk = ~pclk;

  irq_regs uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer0_evt(evt[SRC_T0]), .autoconv_evt(evt[SRC_AC]),
    .ext_pin_evt(evt[SRC_EXT]), .lowvolt_evt(evt[SRC_LV]), .multifunc_evt(evt[SRC_MF]),
    .serial_if_evt(evt[SRC_SI]), .timer1_evt(evt[SRC_T1]), .irq_ack(irq_ack),
    .irq_req(irq_req), .irq_id(irq_id));
  core_model core (.pclk(pclk), .presetn(presetn), .irq_req(irq_req), .irq_id(irq_id),
    .lat(lat), .irq_ack(irq_ack), .taken_id(taken_id));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // The request is held until pready is sampled high, for at most 20 access cycles.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("apb wait", n < 20, 32'h1);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, d, rd, err);
  endtask

  task automatic rdchk(input string name, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0, rd, err);
    chk(name, rd, exp);
    chk("slverr", err, 32'h0);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic reg_test();
    logic [31:0] rd;
    logic        err;
    rdchk("reset a", ADDR_CTRL_A, 32'h0);
    rdchk("reset b", ADDR_CTRL_B, 32'h0);
    wr(ADDR_CTRL_A, 32'hfffffffe);
    rdchk("rw a", ADDR_CTRL_A, 32'h7e);
    wr(ADDR_CTRL_B, 32'hffffffff);
    rdchk("rw b", ADDR_CTRL_B, 32'hff);
    wr(ADDR_CTRL_A, 32'h0);
    wr(ADDR_CTRL_B, 32'h0);
    apb(1'b1, 12'h008, 32'hff, rd, err);
    chk("unmapped err", err, 32'h1);
    apb(1'b0, 12'h008, 32'h0, rd, err);
    chk("unmapped data", rd, 32'h0);
  endtask

  // Flag with enables off, blocked by its own enable, then taken and serviced.
  task automatic src_test(input int s);
    logic [31:0] f;
    logic [31:0] e;
    logic [31:0] g;
    int          n;
    f = 32'h1 << FB[s];
    e = 32'h1 << EB[s];
    g = 32'h1 << A_GIE;
    lat <= s[3:0];
    @(posedge pclk);
    evt[s] <= 1'b1;
    @(posedge pclk);
    evt[s] <= 1'b0;
    if (s < 3)
      rdchk("flag a", ADDR_CTRL_A, f);
    else
      rdchk("flag b", ADDR_CTRL_B, f);
    if (s < 3)
      wr(ADDR_CTRL_A, f | g);
    else
    begin
      wr(ADDR_CTRL_A, g);
      wr(ADDR_CTRL_B, f);
    end
    repeat (3) @(posedge pclk);
    chk("blocked", irq_req, 32'h0);
    wr(s < 3 ? ADDR_CTRL_A : ADDR_CTRL_B, s < 3 ? f | e | g : f | e);
    n = 0;
    while (irq_ack !== 1'b1 && n < 50)
    begin
      @(posedge pclk);
      n++;
    end
    chk("ack seen", n < 50, 32'h1);
    chk("taken id", taken_id, s);
    repeat (3) @(posedge pclk);
    chk("no nesting", irq_req, 32'h0);
    if (s < 3)
      rdchk("serviced a", ADDR_CTRL_A, s < 2 ? e : f | e);
    else
    begin
      rdchk("serviced a", ADDR_CTRL_A, 32'h0);
      rdchk("serviced b", ADDR_CTRL_B, f | e);
    end
    wr(ADDR_CTRL_A, 32'h0);
    wr(ADDR_CTRL_B, 32'h0);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    reg_test();
    for (int s = 0; s < NUM_SRC; s++)
      src_test(s);
    wrap_up();
  end

  // Whole run is well under 1000 cycles; this span only catches a hang.
  initial
  begin
    #40000;
    err_count++;
    wrap_up();
  end
endmodule
`default_nettype wire
